// ===== core/iec_pkg.sv
// Package for the interrupt entry control block: offsets, fields, resets.
// Assumes a 32-bit APB master and a core that uses four clock phases.
package iec_pkg;
    // ==================================================
    // Register byte offsets
    localparam logic [7:0] IEC_CTRL_OFS = 8'h00;
    localparam logic [7:0] IEC_PFLAG_OFS = 8'h04;
    localparam logic [7:0] IEC_PEN_OFS = 8'h08;
    localparam logic [7:0] IEC_OPT_OFS = 8'h0c;
    localparam logic [7:0] IEC_STAT_OFS = 8'h10;
    // ==================================================
    // Control register fields, plus the option register edge bit
    localparam int IEC_GLOBAL_EN_BIT = 7;
    localparam int IEC_PGIE_BIT = 6;
    localparam int IEC_TMR_EN_BIT = 5;
    localparam int IEC_EXT_EN_BIT = 4;
    localparam int IEC_IOC_EN_BIT = 3;
    localparam int IEC_TMR_FLAG_BIT = 2;
    localparam int IEC_EXT_FLAG_BIT = 1;
    localparam int IEC_IOC_FLAG_BIT = 0;
    localparam int IEC_EDGE_BIT = 6;
    // ==================================================
    // Reset values
    localparam logic [7:0] IEC_CTRL_RST = 8'h00;
    localparam logic [7:0] IEC_PEN_RST = 8'h00;
    localparam logic [7:0] IEC_PFLAG_RST = 8'h00;
    localparam logic [7:0] IEC_OPT_RST = 8'h40;
    // ==================================================
    // Vector and timing
    localparam logic [14:0] IEC_VECTOR = 15'h0004;
    localparam int IEC_PHASES = 4;
    localparam logic [1:0] IEC_Q1 = 2'h0;
    localparam logic [1:0] IEC_Q4 = 2'h3;
    typedef enum logic [3:0] {
        IEC_IDLE = 4'h1,
        IEC_FLUSH = 4'h2,
        IEC_PUSH = 4'h4,
        IEC_JUMP = 4'h8
    } iec_state_e;
endpackage

// ===== core/iec_edge_detect.sv
// Edge detector for the external interrupt pin.
// Assumes the pin is already synchronous to core_clk_i.
`timescale 1ns/1ps
module iec_edge_detect
    import iec_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic rising_i,
    output logic edge_o
);
    logic prev_reg;
    logic prev_next;
    logic armed_reg;
    logic armed_next;

    always_comb begin
        prev_next = pin_i;
        armed_next = 1'b1;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            armed_reg <= armed_next;
        end
    end

    // Selected polarity only [R14]
    // Pin may idle high out of reset, so no edge in the first cycle
    assign edge_o = armed_reg &
                    (rising_i ? (pin_i & ~prev_reg) : (~pin_i & prev_reg));
endmodule

// ===== core/iec_top.sv
// Contract
// R1: Any reset leaves interrupts disabled.
// R2: Redirect needs global, source and group enables; here the group enable gates only the peripheral flags.
// R3: Flags set regardless of any enable.
// R4: Entry flushes, clears global, pushes, saves, vectors.
// R5: Events during service set flags only.
// R6: Return pops, restores context, sets global enable.
// R7: Pending flags serviced once global enable returns.
// R8: Firmware clears handled flags before returning.
// R9: Synchronous latency three or four cycles.
// R10: Asynchronous latency three to five cycles.
// R11: Latency independent of instruction length.
// R12: Pin flag sampled every first phase.
// R13: Pin flag may set in phases four, one.
// R14: Edge select picks rising or falling edge.
// R15: Shadow holds W, status, bank, pointers, latch.
// R16: Global enable bit 7, group bit 6.
// R17: Request is OR of gated flags.
//
// Interrupt entry control with APB registers and core sequencing.
// Assumes phase_i counts Q1..Q4 as 0..3 and all inputs are synchronous.
`timescale 1ns/1ps
module iec_top
    import iec_pkg::*;
#(
    parameter int PERIPH_W = 8,
    parameter int PC_W = 15
)(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [1:0] phase_i,
    input wire logic ext_pin_i,
    input wire logic tmr_event_i,
    input wire logic ioc_level_i,
    input wire logic [PERIPH_W-1:0] periph_event_i,
    input wire logic return_from_irq_instr_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [7:0] w_i,
    input wire logic [4:0] status_i,
    input wire logic [4:0] bank_select_reg_i,
    input wire logic [31:0] indirect_pointer_regs_i,
    input wire logic [6:0] pc_high_latch_i,
    output logic flush_o,
    output logic push_o,
    output logic [PC_W-1:0] push_pc_o,
    output logic load_pc_o,
    output logic [PC_W-1:0] load_pc_val_o,
    output logic restore_o,
    output logic [7:0] shadow_w_o,
    output logic [4:0] shadow_status_o,
    output logic [4:0] shadow_bank_o,
    output logic [31:0] shadow_ptr_o,
    output logic [6:0] shadow_pc_high_latch_o,
    output logic irq_pending_o
);
    // ==================================================
    // Registers
    logic [7:0] ctrl_reg, ctrl_next;
    logic [PERIPH_W-1:0] pflag_reg, pflag_next;
    logic [PERIPH_W-1:0] pen_reg, pen_next;
    logic [7:0] opt_reg, opt_next;
    logic ext_edge, ext_seen_reg, ext_seen_next;
    logic wr_en, addr_ok;
    logic [31:0] rdata_next;
    logic [31:0] prdata_reg;
    logic request;
    iec_state_e state_reg, state_next;
    logic [PC_W-1:0] ret_pc_reg, ret_pc_next;
    logic [7:0] sh_w_reg, sh_w_next;
    logic [4:0] sh_st_reg, sh_st_next;
    logic [4:0] sh_bank_reg, sh_bank_next;
    logic [31:0] sh_ptr_reg, sh_ptr_next;
    logic [6:0] sh_pcl_reg, sh_pcl_next;

    function automatic logic sel_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        sel_hit = (a == ofs);
    endfunction

    // Phase helpers shared by pin capture and the sequencer
    function automatic logic at_q1(input logic [1:0] ph);
        at_q1 = (ph == IEC_Q1);
    endfunction

    function automatic logic in_pin_window(input logic [1:0] ph);
        in_pin_window = (ph == IEC_Q4) || (ph == IEC_Q1);
    endfunction

    iec_edge_detect u_edge (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i(ext_pin_i),
        .rising_i(opt_reg[IEC_EDGE_BIT]),
        .edge_o(ext_edge)
    );

    // ==================================================
    // Bus decode; single-cycle answer
    // Writes land in the access phase only
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign addr_ok = sel_hit(paddr_i, IEC_CTRL_OFS) |
                     sel_hit(paddr_i, IEC_PFLAG_OFS) |
                     sel_hit(paddr_i, IEC_PEN_OFS) |
                     sel_hit(paddr_i, IEC_OPT_OFS) |
                     sel_hit(paddr_i, IEC_STAT_OFS);
    assign pready_o = 1'b1;
    // Unmapped access errors out and writes nothing
    assign pslverr_o = psel_i & penable_i & ~addr_ok;
    // Snapshot in setup so the access phase sees settled data
    assign prdata_o = prdata_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (psel_i & ~penable_i & ~pwrite_i) begin
            case (paddr_i)
                IEC_CTRL_OFS: rdata_next[7:0] = ctrl_reg;
                IEC_PFLAG_OFS: rdata_next[PERIPH_W-1:0] = pflag_reg;
                IEC_PEN_OFS: rdata_next[PERIPH_W-1:0] = pen_reg;
                IEC_OPT_OFS: rdata_next[7:0] = opt_reg;
                IEC_STAT_OFS: rdata_next[4:0] = {request, state_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end else begin
            rdata_next = prdata_reg;
        end
    end

    // ==================================================
    // Pin flag capture window: edge held until Q4/Q1 [R13]
    always_comb begin
        ext_seen_next = ext_seen_reg | ext_edge;
        if (in_pin_window(phase_i)) begin
            ext_seen_next = 1'b0;
        end
    end

    // Request: OR of gated flags [R17] [R2]
    always_comb begin
        request = ctrl_reg[IEC_GLOBAL_EN_BIT] &
            ((ctrl_reg[IEC_TMR_EN_BIT] & ctrl_reg[IEC_TMR_FLAG_BIT]) |
             (ctrl_reg[IEC_EXT_EN_BIT] & ctrl_reg[IEC_EXT_FLAG_BIT]) |
             (ctrl_reg[IEC_IOC_EN_BIT] & ctrl_reg[IEC_IOC_FLAG_BIT]) |
             (ctrl_reg[IEC_PGIE_BIT] & (|(pflag_reg & pen_reg))));
    end
    assign irq_pending_o = request;

    // ==================================================
    // Register updates; hardware set wins over software clear [R3]
    always_comb begin
        ctrl_next = ctrl_reg;
        pflag_next = pflag_reg;
        pen_next = pen_reg;
        opt_next = opt_reg;
        if (wr_en) begin
            case (paddr_i)
                IEC_CTRL_OFS: ctrl_next[7:1] = pwdata_i[7:1];
                IEC_PFLAG_OFS: pflag_next = pwdata_i[PERIPH_W-1:0];
                IEC_PEN_OFS: pen_next = pwdata_i[PERIPH_W-1:0];
                IEC_OPT_OFS: opt_next = pwdata_i[7:0];
                default: ;
            endcase
        end
        // Change flag is read-only, follows its source level
        ctrl_next[IEC_IOC_FLAG_BIT] = ioc_level_i;
        pflag_next = pflag_next | periph_event_i;                // [R3]
        if (tmr_event_i) begin
            ctrl_next[IEC_TMR_FLAG_BIT] = 1'b1;                  // [R3]
        end
        if ((ext_edge | ext_seen_reg) &&
            in_pin_window(phase_i)) begin
            ctrl_next[IEC_EXT_FLAG_BIT] = 1'b1;                  // [R13] [R14]
        end
        // Cleared at the flush step so later events only pend
        if (state_reg == IEC_FLUSH) begin
            ctrl_next[IEC_GLOBAL_EN_BIT] = 1'b0;                 // [R4] [R5]
        end
        if (return_from_irq_instr_i && state_reg == IEC_IDLE) begin
            ctrl_next[IEC_GLOBAL_EN_BIT] = 1'b1;                 // [R6] [R7]
        end
    end

    // ==================================================
    // Entry sequencer, one step per instruction cycle at Q1, except JUMP, which returns to IDLE on the next clock [R12]
    always_comb begin
        state_next = state_reg;
        ret_pc_next = ret_pc_reg;
        sh_w_next = sh_w_reg;
        sh_st_next = sh_st_reg;
        sh_bank_next = sh_bank_reg;
        sh_ptr_next = sh_ptr_reg;
        sh_pcl_next = sh_pcl_reg;
        // Fixed three-step walk keeps latency free of instr length [R9]
        // [R10] [R11]
        case (state_reg)
            IEC_IDLE: begin
                if (request && at_q1(phase_i)) begin
                    state_next = IEC_FLUSH;                      // [R4]
                    // Context copied at the decision edge, before the core
                    ret_pc_next = pc_i;
                    sh_w_next = w_i;                             // [R15]
                    sh_st_next = status_i;
                    sh_bank_next = bank_select_reg_i;
                    sh_ptr_next = indirect_pointer_regs_i;
                    sh_pcl_next = pc_high_latch_i;
                end
            end
            IEC_FLUSH: begin
                if (at_q1(phase_i)) begin
                    state_next = IEC_PUSH;
                end
            end
            IEC_PUSH: begin
                if (at_q1(phase_i)) begin
                    state_next = IEC_JUMP;
                end
            end
            IEC_JUMP: state_next = IEC_IDLE;
            default: state_next = IEC_IDLE;
        endcase
    end

    // Core strobes; flush, push and load one clock each, restore as long as the return input while the sequencer is in IDLE
    assign flush_o = (state_reg == IEC_FLUSH) && at_q1(phase_i);
    assign push_o = (state_reg == IEC_PUSH) && at_q1(phase_i);
    assign load_pc_o = (state_reg == IEC_JUMP);                  // [R4]
    assign restore_o = return_from_irq_instr_i &&
                       (state_reg == IEC_IDLE);                  // [R6]
    assign push_pc_o = ret_pc_reg;
    // Vector fixed; cut to the PC width on purpose
    assign load_pc_val_o = IEC_VECTOR[PC_W-1:0];
    assign shadow_w_o = sh_w_reg;
    assign shadow_status_o = sh_st_reg;
    assign shadow_bank_o = sh_bank_reg;
    assign shadow_ptr_o = sh_ptr_reg;
    assign shadow_pc_high_latch_o = sh_pcl_reg;

    // ==================================================
    // Register file state; reset clears global enable [R1]
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= IEC_CTRL_RST;                            // [R1] [R16]
            pflag_reg <= PERIPH_W'(IEC_PFLAG_RST);
            pen_reg <= PERIPH_W'(IEC_PEN_RST);
            opt_reg <= IEC_OPT_RST;
        end else begin
            ctrl_reg <= ctrl_next;
            pflag_reg <= pflag_next;
            pen_reg <= pen_next;
            opt_reg <= opt_next;
        end
    end

    // ==================================================
    // Pin edge holding state
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_seen_reg <= 1'b0;
        end else begin
            ext_seen_reg <= ext_seen_next;
        end
    end

    // ==================================================
    // Read data snapshot
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= rdata_next;
        end
    end

    // ==================================================
    // Sequencer and shadow state; idle out of any reset [R1]
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= IEC_IDLE;
            ret_pc_reg <= '0;
            sh_w_reg <= 8'h00;
            sh_st_reg <= 5'h00;
            sh_bank_reg <= 5'h00;
            sh_ptr_reg <= 32'h0000_0000;
            sh_pcl_reg <= 7'h00;
        end else begin
            state_reg <= state_next;
            ret_pc_reg <= ret_pc_next;
            sh_w_reg <= sh_w_next;
            sh_st_reg <= sh_st_next;
            sh_bank_reg <= sh_bank_next;
            sh_ptr_reg <= sh_ptr_next;
            sh_pcl_reg <= sh_pcl_next;
        end
    end
endmodule

// ===== testbench/iec_top_sva.sv
// Checker for interrupt entry timing at the top ports.
// Assumes phase_i advances one phase per clock.
`timescale 1ns/1ps
module iec_top_sva
    import iec_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] phase_i,
    input wire logic flush_o,
    input wire logic push_o,
    input wire logic load_pc_o,
    input wire logic [14:0] load_pc_val_o,
    input wire logic restore_o,
    input wire logic return_from_irq_instr_i,
    input wire logic irq_pending_o,
    input wire logic [14:0] pc_i,
    input wire logic [14:0] push_pc_o
);
    // ==================================================
    // Entry and return
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_entry;
        flush_o ##4 push_o ##1 load_pc_o;
    endsequence
    AST_RESET_OFF: assert property ($fell(rst_i) |-> !irq_pending_o)
        else $error("request active after reset");
    AST_ENTRY_SEQ: assert property (flush_o |-> s_entry)
        else $error("entry steps out of order");
    AST_VECTOR: assert property (load_pc_o |-> load_pc_val_o == IEC_VECTOR)
        else $error("wrong vector");
    AST_PUSH_CAUSE: assert property (push_o |-> $past(flush_o, 4))
        else $error("push without flush");
    AST_FLUSH_Q1: assert property (flush_o |-> phase_i == IEC_Q1)
        else $error("flush off the first phase");
    AST_NO_REENTRY: assert property (flush_o |=> !flush_o [*8])
        else $error("second entry during service");
    AST_NEEDS_REQ: assert property (!irq_pending_o [*6] |=> !flush_o)
        else $error("entry without request");
    // Bound covers all four arrival phases of the event
    AST_LATENCY: assert property ($rose(irq_pending_o) |-> ##[1:20] load_pc_o)
        else $error("entry too slow");
    AST_RESTORE: assert property (restore_o |-> return_from_irq_instr_i)
        else $error("restore without return");
    AST_PUSH_PC: assert property (push_o |->
        push_pc_o == $past(pc_i, 8))
        else $error("pushed PC differs from PC at entry");
endmodule

bind iec_top iec_top_sva i_sva (.core_clk_i, .rst_i, .phase_i, .flush_o,
    .push_o, .load_pc_o, .load_pc_val_o, .restore_o,
    .return_from_irq_instr_i, .irq_pending_o, .pc_i, .push_pc_o);

// ===== testbench/iec_core_model.sv
// Core model: phases, program counter and working register.
// Assumes load_pc_i lasts one clock and restore_i ends service.
`timescale 1ns/1ps
module iec_core_model
    import iec_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic load_pc_i,
    input wire logic [14:0] load_pc_val_i,
    input wire logic restore_i,
    output logic [1:0] phase_o,
    output logic [14:0] pc_o,
    output logic [7:0] w_o
);
    // ==================================================
    // Core sequencing
    logic in_isr;
    // Service code overwrites W, so a live copy cannot pass as saved
    assign w_o = in_isr ? 8'h33 : 8'h5a;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_o <= IEC_Q1;
            pc_o <= '0;
            in_isr <= 1'h0;
        end else begin
            phase_o <= phase_o + 2'h1;
            pc_o <= load_pc_i ? load_pc_val_i : pc_o + 15'(phase_o == IEC_Q4);
            in_isr <= load_pc_i | (in_isr & ~restore_i);
        end
    end
endmodule

// ===== testbench/interrupt_entry_control_bench.sv
// Bench: register rows, then entry, return, pin and reset cases.
// Assumes the core model supplies phase, PC and context.
`timescale 1ns/1ps
module interrupt_entry_control_bench import iec_pkg::*;;
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] e;
        logic x;
    } iec_row_s;
    logic core_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic ext_pin_i = 0, tmr_event_i = 0, return_from_irq_instr_i = 0;
    logic [7:0] paddr_i = '0, periph_event_i = '0, w_i, shadow_w_o;
    logic [31:0] pwdata_i = '0, prdata_o, indirect_pointer_regs_i;
    logic [31:0] shadow_ptr_o, rd;
    logic pready_o, pslverr_o, flush_o, push_o, load_pc_o, restore_o, er;
    logic irq_pending_o, ioc_level_i = 0;
    logic [1:0] phase_i;
    logic [14:0] pc_i, push_pc_o, load_pc_val_o;
    logic [4:0] status_i, bank_select_reg_i, shadow_status_o, shadow_bank_o;
    logic [6:0] pc_high_latch_i, shadow_pc_high_latch_o;
    int err_total = 0, comparisons = 0, cyc = 0, n;
    iec_row_s rows [6] = '{'{IEC_CTRL_OFS, 1'h0, 32'h0, 32'h0, 1'h0},
        '{IEC_OPT_OFS, 1'h0, 32'h0, 32'h40, 1'h0},
        '{IEC_PEN_OFS, 1'h1, 32'hff, 32'h0, 1'h0},
        '{IEC_PEN_OFS, 1'h0, 32'h0, 32'hff, 1'h0},
        '{IEC_PEN_OFS, 1'h1, 32'h0, 32'h0, 1'h0},
        '{8'h20, 1'h0, 32'h0, 32'h0, 1'h1}};
    assign status_i = w_i[4:0];
    assign bank_select_reg_i = w_i[7:3];
    assign indirect_pointer_regs_i = {4{w_i}};
    assign pc_high_latch_i = w_i[6:0];
    iec_top i_dut (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .phase_i,
        .ext_pin_i, .tmr_event_i, .ioc_level_i, .periph_event_i,
        .return_from_irq_instr_i, .pc_i, .w_i, .status_i,
        .bank_select_reg_i, .indirect_pointer_regs_i, .pc_high_latch_i,
        .flush_o, .push_o, .push_pc_o, .load_pc_o, .load_pc_val_o,
        .restore_o, .shadow_w_o, .shadow_status_o, .shadow_bank_o,
        .shadow_ptr_o, .shadow_pc_high_latch_o, .irq_pending_o);
    iec_core_model i_core (.core_clk_i, .rst_i, .load_pc_i(load_pc_o),
        .load_pc_val_i(load_pc_val_o), .restore_i(restore_o),
        .phase_o(phase_i), .pc_o(pc_i), .w_o(w_i));
    // ==================================================
    // Tasks
    task automatic test_done();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
            input logic [31:0] d);
        int k;
        @(posedge core_clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'h1;
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (pready_o !== 1'h1 && k < 20);
        if (pready_o !== 1'h1) err_total++;
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'h0, 32'h0);
        chk_word(rd, e);
    endtask
    task automatic ev(input logic t, input logic [7:0] p);
        @(posedge core_clk_i);
        tmr_event_i <= t;
        periph_event_i <= p;
        @(posedge core_clk_i);
        tmr_event_i <= 1'h0;
        periph_event_i <= 8'h0;
    endtask
    task automatic wait_load();
        n = 0;
        do begin
            @(posedge core_clk_i);
            #1 n++;
        end while (load_pc_o !== 1'h1 && n < 40);
        chk_word(32'(load_pc_o), 32'h1);
    endtask
    task automatic ret();
        @(posedge core_clk_i);
        return_from_irq_instr_i <= 1'h1;
        #1 chk_word(32'(restore_o), 32'h1);
        @(posedge core_clk_i);
        return_from_irq_instr_i <= 1'h0;
    endtask
    // ==================================================
    // Stimulus
    initial forever #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk_word(rd, rows[i].e);
            chk_word(32'(er), 32'(rows[i].x));
        end
        $display("register rows done");
        ev(1'h1, 8'h01);
        rdc(IEC_CTRL_OFS, 32'h04);
        rdc(IEC_PFLAG_OFS, 32'h01);
        apb(IEC_PEN_OFS, 1'h1, 32'h01);
        apb(IEC_CTRL_OFS, 1'h1, 32'h84);
        #1 chk_word(32'(irq_pending_o), 32'h0);
        apb(IEC_CTRL_OFS, 1'h1, 32'hc4);
        wait_load();
        chk_word(shadow_ptr_o, 32'h5a5a5a5a);
        chk_word({20'h0, shadow_status_o, shadow_pc_high_latch_o}, 32'hd5a);
        chk_word({27'h0, shadow_bank_o}, 32'h0b);
        ev(1'h0, 8'h02);
        rdc(IEC_CTRL_OFS, 32'h44);
        rdc(IEC_PFLAG_OFS, 32'h03);
        chk_word(32'(irq_pending_o), 32'h0);
        apb(IEC_PFLAG_OFS, 1'h1, 32'h0);
        apb(IEC_CTRL_OFS, 1'h1, 32'h40);
        ret();
        rdc(IEC_CTRL_OFS, 32'hc0);
        chk_word({24'h0, shadow_w_o}, 32'h5a);
        $display("peripheral entry done");
        apb(IEC_CTRL_OFS, 1'h1, 32'he0);
        ev(1'h1, 8'h0);
        wait_load();
        chk_word(32'(n <= 15), 32'h1);
        apb(IEC_CTRL_OFS, 1'h1, 32'h20);
        ret();
        rdc(IEC_CTRL_OFS, 32'ha0);
        $display("timer latency done");
        apb(IEC_CTRL_OFS, 1'h1, 32'h00);
        ioc_level_i <= 1'h1;
        rdc(IEC_CTRL_OFS, 32'h01);
        ioc_level_i <= 1'h0;
        apb(IEC_OPT_OFS, 1'h1, 32'h00);
        ext_pin_i <= 1'h1;
        repeat (8) @(posedge core_clk_i);
        rdc(IEC_CTRL_OFS, 32'h00);
        ext_pin_i <= 1'h0;
        repeat (8) @(posedge core_clk_i);
        rdc(IEC_CTRL_OFS, 32'h02);
        apb(IEC_CTRL_OFS, 1'h1, 32'h92);
        wait_load();
        apb(IEC_CTRL_OFS, 1'h1, 32'h10);
        ret();
        apb(IEC_CTRL_OFS, 1'h1, 32'h00);
        apb(IEC_OPT_OFS, 1'h1, 32'h40);
        ext_pin_i <= 1'h1;
        repeat (8) @(posedge core_clk_i);
        rdc(IEC_CTRL_OFS, 32'h02);
        $display("pin edge done");
        @(posedge core_clk_i);
        rst_i <= 1'h1;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'h0;
        rdc(IEC_CTRL_OFS, 32'h00);
        rdc(IEC_OPT_OFS, 32'h40);
        $display("second reset done");
        test_done();
    end
endmodule
